// File: verilog/hub_port_defines.svh
// hub_port_defines.svh: timing counts and the port count for port power signalling
// assumes a 50 MHz reference clock
`ifndef HUB_PORT_DEFINES_SVH
`define HUB_PORT_DEFINES_SVH
`define CLK_PERIOD_NS        20
// upstream power must be seen stable this long before connect, in us
`define VBUS_DEBOUNCE_US     100
`define VBUS_DEBOUNCE_CYC    ((`VBUS_DEBOUNCE_US * 1000) / `CLK_PERIOD_NS)
// over-current must be seen this long before it is believed, in us
`define OC_FILTER_US         8
`define OC_FILTER_CYC        ((`OC_FILTER_US * 1000) / `CLK_PERIOD_NS)
`define PORT_COUNT           3
`endif

// File: verilog/hub_port_pkg.sv
// hub_port_pkg.sv: types shared by the port power signalling design
// assumes hub_port_defines.svh for the numbers
package hub_port_pkg;
  typedef enum logic [2:0] {
    PORT_OFF   = 3'h1,
    PORT_ON    = 3'h2,
    PORT_FAULT = 3'h4
  } port_state_e;
endpackage

// File: verilog/port_ctrl_if.sv
// port_ctrl_if.sv: carries per-port control and status between top and port slice
// assumes one clock domain
`timescale 1ns/10ps
interface port_ctrl_if;
  logic power_request;
  logic overcurrent;
  logic powered;
  logic fault_flag;
  logic fault_clear;
  modport top
  (
    output power_request,
    output overcurrent,
    output fault_clear,
    input  powered,
    input  fault_flag
  );
  modport slice
  (
    input  power_request,
    input  overcurrent,
    input  fault_clear,
    output powered,
    output fault_flag
  );
endinterface

// File: verilog/port_power_slice.sv
// port_power_slice.sv: one downstream port's power state machine with fault latch
// assumes a synchronised active-high over-current level from the top
`timescale 1ns/10ps
`include "hub_port_defines.svh"
module port_power_slice #(
  parameter int FILTER_CYC = `OC_FILTER_CYC
) (
  input  wire logic  clk_i,
  input  wire logic  rst_ni,
  port_ctrl_if.slice ctl
);
  localparam int CW = $clog2(FILTER_CYC + 1);
  hub_port_pkg::port_state_e state_q, state_d;
  logic [CW-1:0]             filt_q, filt_d;
  logic                      flag_q, flag_d;
  logic                      oc_seen;

  ////////////////////////////////////////////////////////////////////////
  // next state: filter over-current, latch fault, drop power on fault
  always_comb
  begin
    state_d = state_q;
    filt_d  = ctl.overcurrent ? filt_q : '0;
    oc_seen = 1'b0;
    if (ctl.overcurrent)
    begin
      if (filt_q == CW'(FILTER_CYC))
        oc_seen = 1'b1;
      else
        filt_d = filt_q + CW'(1);
    end
    // set wins over clear
    flag_d = oc_seen | (flag_q & ~ctl.fault_clear);
    case (state_q)
      hub_port_pkg::PORT_OFF:
        if (ctl.power_request && !oc_seen)
          state_d = hub_port_pkg::PORT_ON;
      hub_port_pkg::PORT_ON:
        if (oc_seen)
          state_d = hub_port_pkg::PORT_FAULT;
        else if (!ctl.power_request)
          state_d = hub_port_pkg::PORT_OFF;
      hub_port_pkg::PORT_FAULT:
        if (!ctl.power_request)
          state_d = hub_port_pkg::PORT_OFF;
      default:
        state_d = hub_port_pkg::PORT_OFF;
    endcase
  end

  // state registers
  always_ff @(posedge clk_i or negedge rst_ni)
  begin
    if (!rst_ni)
    begin
      state_q <= hub_port_pkg::PORT_OFF;
      filt_q  <= '0;
      flag_q  <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      filt_q  <= filt_d;
      flag_q  <= flag_d;
    end
  end

  assign ctl.powered    = (state_q == hub_port_pkg::PORT_ON);
  assign ctl.fault_flag = flag_q;
endmodule // port_power_slice

// File: verilog/hub_port_power.sv
// hub_port_power.sv: downstream port power, over-current and LED signalling
// assumes 50 MHz REF_CLK_I, pins sampled asynchronously, strap static
`timescale 1ns/10ps
`include "hub_port_defines.svh"

module hub_port_power #(
  parameter int NPORT       = `PORT_COUNT,
  parameter int VBUS_DB_CYC = `VBUS_DEBOUNCE_CYC,
  parameter int OC_CYC      = `OC_FILTER_CYC
) (
  input  wire logic             REF_CLK_I,
  input  wire logic             RESETN_I,
  input  wire logic             UPSTREAM_POWER_SENSE_I,
  input  wire logic             PORT_POWER_POLARITY_STRAP_I,
  input  wire logic [NPORT-1:0] PORT_OVERCURRENT_SENSE_L_I,
  input  wire logic [NPORT-1:0] PORT_POWER_REQUEST_I,
  input  wire logic [NPORT-1:0] PORT_ACTIVE_I,
  input  wire logic             LED_SUPPORT_ENABLE_I,
  input  wire logic [NPORT-1:0] OVERCURRENT_CLEAR_I,
  output logic                  UPSTREAM_DPLUS_PULLUP_O,
  output logic [NPORT-1:0]      PORT_POWER_ENABLE_O,
  output logic [NPORT-1:0]      PORT_POWER_ENABLE_OE_O,
  output logic [NPORT-1:0]      PORT_OVERCURRENT_FLAG_O,
  output logic [NPORT-1:0]      PORT_GREEN_LED_L_O,
  output logic [NPORT-1:0]      PORT_GREEN_LED_L_OE_O
);
  localparam int VW = $clog2(VBUS_DB_CYC + 1);

  ////////////////////////////////////////////////////////////////////////
  // three-stage synchronisers for the upstream power and strap pins
  logic [2:0]       vbus_sync_q, vbus_sync_d;
  logic [2:0]       pol_sync_q, pol_sync_d;
  logic             vbus_lvl_q, vbus_lvl_d;
  logic             pol_lvl_q, pol_lvl_d;

  // shift pins in; accept a change once stages two and three agree
  always_comb
  begin
    vbus_sync_d = {vbus_sync_q[1:0], UPSTREAM_POWER_SENSE_I};
    pol_sync_d  = {pol_sync_q[1:0], PORT_POWER_POLARITY_STRAP_I};
    vbus_lvl_d  = (vbus_sync_q[1] == vbus_sync_q[2]) ? vbus_sync_q[2] : vbus_lvl_q;
    pol_lvl_d   = (pol_sync_q[1] == pol_sync_q[2]) ? pol_sync_q[2] : pol_lvl_q;
  end

  // power and strap synchroniser registers
  always_ff @(posedge REF_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      vbus_sync_q <= 3'h0;
      pol_sync_q  <= 3'h0;
      vbus_lvl_q  <= 1'b0;
      pol_lvl_q   <= 1'b0;
    end
    else
    begin
      vbus_sync_q <= vbus_sync_d;
      pol_sync_q  <= pol_sync_d;
      vbus_lvl_q  <= vbus_lvl_d;
      pol_lvl_q   <= pol_lvl_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // three-stage synchronisers for the over-current pins, turned active high
  logic [NPORT-1:0] oc_s1_q, oc_s2_q, oc_s3_q;
  logic [NPORT-1:0] oc_s1_d, oc_s2_d, oc_s3_d;
  logic [NPORT-1:0] oc_lvl_q, oc_lvl_d;

  // a port's level changes only once stages two and three agree
  always_comb
  begin
    oc_s1_d = ~PORT_OVERCURRENT_SENSE_L_I;
    oc_s2_d = oc_s1_q;
    oc_s3_d = oc_s2_q;
    for (int i = 0; i < NPORT; i++)
      oc_lvl_d[i] = (oc_s2_q[i] == oc_s3_q[i]) ? oc_s3_q[i] : oc_lvl_q[i];
  end

  // over-current synchroniser registers
  always_ff @(posedge REF_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      oc_s1_q  <= '0;
      oc_s2_q  <= '0;
      oc_s3_q  <= '0;
      oc_lvl_q <= '0;
    end
    else
    begin
      oc_s1_q  <= oc_s1_d;
      oc_s2_q  <= oc_s2_d;
      oc_s3_q  <= oc_s3_d;
      oc_lvl_q <= oc_lvl_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // upstream power debounce drives the D+ pull-up
  logic [VW-1:0] vbus_cnt_q, vbus_cnt_d;
  logic          pullup_q, pullup_d;

  // pull-up on after power stable for debounce time, off at once on loss
  always_comb
  begin
    vbus_cnt_d = '0;
    pullup_d   = 1'b0;
    if (vbus_lvl_q)
    begin
      pullup_d = pullup_q;
      if (vbus_cnt_q == VW'(VBUS_DB_CYC))
        pullup_d = 1'b1;
      else
        vbus_cnt_d = vbus_cnt_q + VW'(1);
      if (vbus_cnt_q == VW'(VBUS_DB_CYC))
        vbus_cnt_d = vbus_cnt_q;
    end
  end

  // debounce registers
  always_ff @(posedge REF_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      vbus_cnt_q <= '0;
      pullup_q   <= 1'b0;
    end
    else
    begin
      vbus_cnt_q <= vbus_cnt_d;
      pullup_q   <= pullup_d;
    end
  end

  assign UPSTREAM_DPLUS_PULLUP_O = pullup_q;

  ////////////////////////////////////////////////////////////////////////
  // polarity strap captured after reset release
  logic [2:0] pol_fill_q, pol_fill_d;
  logic       pol_cap_q, pol_cap_d;
  logic       pol_valid_q, pol_valid_d;

  // latch only once all three sync stages hold real samples, not reset zeros,
  // else a high strap would be taken as low and power the ports up
  always_comb
  begin
    pol_fill_d  = {pol_fill_q[1:0], 1'b1};
    pol_valid_d = pol_valid_q | (pol_fill_q[2] & (pol_sync_q[1] == pol_sync_q[2]));
    pol_cap_d   = pol_valid_q ? pol_cap_q : pol_lvl_d;
  end

  // strap registers
  always_ff @(posedge REF_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      pol_fill_q  <= 3'h0;
      pol_cap_q   <= 1'b0;
      pol_valid_q <= 1'b0;
    end
    else
    begin
      pol_fill_q  <= pol_fill_d;
      pol_cap_q   <= pol_cap_d;
      pol_valid_q <= pol_valid_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-port power slices
  logic [NPORT-1:0] powered;

  genvar g;
  generate
    for (g = 0; g < NPORT; g++)
    begin : g_port
      port_ctrl_if ctl ();
      assign ctl.power_request = PORT_POWER_REQUEST_I[g];
      assign ctl.overcurrent   = oc_lvl_q[g];
      assign ctl.fault_clear   = OVERCURRENT_CLEAR_I[g];
      assign powered[g]        = ctl.powered;
      assign PORT_OVERCURRENT_FLAG_O[g] = ctl.fault_flag;
      port_power_slice #(
        .FILTER_CYC (OC_CYC)
      ) u_slice (
        .clk_i  (REF_CLK_I),
        .rst_ni (RESETN_I),
        .ctl    (ctl.slice)
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // pin drive: during reset the raw strap sets the off level combinationally
  logic pol_use;

  always_comb
  begin
    pol_use = pol_valid_q ? pol_cap_q : PORT_POWER_POLARITY_STRAP_I;
    if (!RESETN_I)
      PORT_POWER_ENABLE_O = {NPORT{~PORT_POWER_POLARITY_STRAP_I}};
    else
      PORT_POWER_ENABLE_O = pol_use ? powered : ~powered;
  end

  assign PORT_POWER_ENABLE_OE_O = {NPORT{1'b1}};

  // green leds low when active and powered; released without led support or in reset
  always_comb
  begin
    PORT_GREEN_LED_L_O    = ~(PORT_ACTIVE_I & powered);
    PORT_GREEN_LED_L_OE_O = {NPORT{LED_SUPPORT_ENABLE_I & RESETN_I}};
  end
endmodule // hub_port_power

// File: tb/hub_port_power_monitor.sv
// hub_port_power_monitor.sv: pin-level assertions for the port power block
// assumes it is bound into hub_port_power and one clock domain
`timescale 1ns/10ps
module hub_port_power_monitor #(
  parameter int NPORT = 3
) (
  input wire logic             REF_CLK_I,
  input wire logic             RESETN_I,
  input wire logic             UPSTREAM_POWER_SENSE_I,
  input wire logic             PORT_POWER_POLARITY_STRAP_I,
  input wire logic [NPORT-1:0] PORT_OVERCURRENT_SENSE_L_I,
  input wire logic [NPORT-1:0] PORT_POWER_REQUEST_I,
  input wire logic [NPORT-1:0] PORT_ACTIVE_I,
  input wire logic             LED_SUPPORT_ENABLE_I,
  input wire logic [NPORT-1:0] OVERCURRENT_CLEAR_I,
  input wire logic             UPSTREAM_DPLUS_PULLUP_O,
  input wire logic [NPORT-1:0] PORT_POWER_ENABLE_O,
  input wire logic [NPORT-1:0] PORT_POWER_ENABLE_OE_O,
  input wire logic [NPORT-1:0] PORT_OVERCURRENT_FLAG_O,
  input wire logic [NPORT-1:0] PORT_GREEN_LED_L_O,
  input wire logic [NPORT-1:0] PORT_GREEN_LED_L_OE_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RESETN_I);
  // asserted power bits whatever the strap polarity
  logic [NPORT-1:0] pwr_on;
  assign pwr_on = PORT_POWER_ENABLE_O ^ {NPORT{~PORT_POWER_POLARITY_STRAP_I}};
  //////////////////////////////////////////////////////////////////////////////
  // power enables and over-current flags
  rst_off_a: assert property (disable iff (1'b0) !RESETN_I |-> pwr_on == '0)
    else $error("power enabled in reset");
  oe_on_a: assert property (&PORT_POWER_ENABLE_OE_O)
    else $error("enable pin released");
  pwr_req_a: assert property ((pwr_on & ~$past(PORT_POWER_REQUEST_I)) == '0)
    else $error("power without request");
  oc_off_a: assert property ($fell(PORT_OVERCURRENT_SENSE_L_I[1])
    |-> ##[1:20] !pwr_on[1]) else $error("power kept on fault");
  flag_off_a: assert property (
    (PORT_OVERCURRENT_FLAG_O & ~$past(PORT_OVERCURRENT_FLAG_O) & pwr_on) == '0)
    else $error("flag set with power on");
  flag_hold_a: assert property (
    ($past(PORT_OVERCURRENT_FLAG_O) & ~$past(OVERCURRENT_CLEAR_I) & ~PORT_OVERCURRENT_FLAG_O) == '0)
    else $error("flag lost without clear");
  //////////////////////////////////////////////////////////////////////////////
  // connect pull-up
  pup_drop_a: assert property (!UPSTREAM_POWER_SENSE_I [*8] |-> !UPSTREAM_DPLUS_PULLUP_O)
    else $error("pull-up without power");
  pup_wait_a: assert property ($rose(UPSTREAM_POWER_SENSE_I)
    |=> !UPSTREAM_DPLUS_PULLUP_O [*8]) else $error("pull-up too early");
  //////////////////////////////////////////////////////////////////////////////
  // green indicators
  led_oe_a: assert property ($past(RESETN_I) && $stable(LED_SUPPORT_ENABLE_I)
    |-> PORT_GREEN_LED_L_OE_O == {NPORT{LED_SUPPORT_ENABLE_I}}) else $error("led drive wrong");
  led_lit_a: assert property (LED_SUPPORT_ENABLE_I
    |-> PORT_GREEN_LED_L_O == ~(PORT_ACTIVE_I & pwr_on)) else $error("led level wrong");
  cover property ($rose(UPSTREAM_DPLUS_PULLUP_O));
  cover property ($rose(PORT_OVERCURRENT_FLAG_O[1]));
  cover property (LED_SUPPORT_ENABLE_I && !PORT_GREEN_LED_L_O[0]);
endmodule // hub_port_power_monitor
bind hub_port_power hub_port_power_monitor #(.NPORT(NPORT)) CHK_I (.*);

// File: tb/oc_monitor_model.sv
// oc_monitor_model.sv: external current monitors on the over-current pins
// assumes the bench raises fault_i per port; a pull-up holds idle pins high
`timescale 1ns/10ps
module oc_monitor_model (
  input  wire logic [2:0] fault_i,
  output wire logic [2:0] sense_l_o
);
  // pulled low on fault, pull-up level otherwise
  assign sense_l_o = ~fault_i;
endmodule // oc_monitor_model

// File: tb/testbench.sv
// testbench.sv: self-checking bench for downstream port power signalling
// assumes the design under verilog/ and the current monitor model
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module testbench;
  logic       clk, rst_n, vbus, pol, led_en, pup;
  logic [2:0] fault, req, act, clr, pwr, pwr_oe, flag, led_l, led_oe;
  wire  [2:0] ocs_l;
  int         n_mismatch = 0;
  int         checked    = 0;
  hub_port_power #(.VBUS_DB_CYC(10), .OC_CYC(4)) DUT (
    .REF_CLK_I(clk), .RESETN_I(rst_n), .UPSTREAM_POWER_SENSE_I(vbus),
    .PORT_POWER_POLARITY_STRAP_I(pol), .PORT_OVERCURRENT_SENSE_L_I(ocs_l),
    .PORT_POWER_REQUEST_I(req), .PORT_ACTIVE_I(act), .LED_SUPPORT_ENABLE_I(led_en),
    .OVERCURRENT_CLEAR_I(clr), .UPSTREAM_DPLUS_PULLUP_O(pup), .PORT_POWER_ENABLE_O(pwr),
    .PORT_POWER_ENABLE_OE_O(pwr_oe), .PORT_OVERCURRENT_FLAG_O(flag),
    .PORT_GREEN_LED_L_O(led_l), .PORT_GREEN_LED_L_OE_O(led_oe));
  oc_monitor_model PEER (.fault_i(fault), .sense_l_o(ocs_l));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic summarize;
    if (n_mismatch == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // reset level follows strap, then polarity p powers on and off
  task automatic t_polarity(input logic p);
    cyc(1);
    rst_n = 1'b0;
    req   = 3'h0;
    pol   = ~p;
    #1 `CHK(pwr, {3{p}})
    cyc(1);
    pol = p;
    #1 `CHK(pwr, {3{~p}})
    cyc(3);
    rst_n = 1'b1;
    cyc(5);
    `CHK(pwr, {3{~p}})
    req = 3'h7;
    cyc(2);
    `CHK(pwr, {3{p}})
    `CHK(pwr_oe, 3'h7)
    req = 3'h0;
    cyc(2);
    `CHK(pwr, {3{~p}})
  endtask
  // pull-up waits for settled power and drops with it
  task automatic t_vbus;
    int n;
    vbus = 1'b1;
    for (n = 0; n < 40 && pup !== 1'b1; n++) cyc(1);
    `CHK(n > 9, 1'b1)
    `CHK(pup, 1'b1)
    vbus = 1'b0;
    cyc(8);
    `CHK(pup, 1'b0)
  endtask
  // fault on port 1, clear refused while held, re-request restores power
  task automatic t_oc;
    int n;
    req = 3'h7;
    cyc(2);
    fault = 3'h2;
    for (n = 0; n < 30 && flag[1] !== 1'b1; n++) cyc(1);
    `CHK(flag, 3'h2)
    `CHK(pwr, 3'h5)
    clr = 3'h2;
    cyc(1);
    clr = 3'h0;
    cyc(1);
    `CHK(flag, 3'h2)
    fault = 3'h0;
    cyc(10);
    clr = 3'h2;
    cyc(1);
    clr = 3'h0;
    cyc(1);
    `CHK(flag, 3'h0)
    `CHK(pwr, 3'h5)
    req = 3'h5;
    cyc(2);
    req = 3'h7;
    cyc(2);
    `CHK(pwr, 3'h7)
  endtask
  // leds released when unsupported, lit low on active powered ports
  task automatic t_led;
    act = 3'h5;
    cyc(2);
    `CHK(led_oe, 3'h0)
    led_en = 1'b1;
    req    = 3'h3;
    cyc(3);
    `CHK(led_oe, 3'h7)
    `CHK(led_l, 3'h6)
    act = 3'h2;
    cyc(1);
    `CHK(led_l, 3'h5)
  endtask
  // main sequence
  initial
  begin
    rst_n  = 1'b0;
    vbus   = 1'b0;
    pol    = 1'b0;
    led_en = 1'b0;
    fault  = 3'h0;
    req    = 3'h0;
    act    = 3'h0;
    clr    = 3'h0;
    t_polarity(1'b0);
    t_polarity(1'b1);
    t_vbus;
    t_oc;
    t_led;
    summarize;
  end
  // watchdog well beyond the fewer than a hundred cycles the tests need
  initial
  begin
    #200000;
    n_mismatch++;
    summarize;
  end
endmodule // testbench
